// ---- verilog/iosd_decoder.sv ----
// peripheral register space decoder with scratch, flag and control registers
`timescale 1ns/1ps
module iosd_decoder (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire iosd_pkg::iosd_data_req_t data_req_i,
  input  wire iosd_pkg::iosd_port_req_t port_req_i,
  input  wire iosd_pkg::iosd_bit_req_t  bit_req_i,
  input  wire logic [7:0]              flag_evt_i,
  output logic [7:0]                   rdata_o,
  output logic                         rvalid_o,
  output logic                         test_bit_o,
  output logic                         test_valid_o,
  output logic [7:0]                   flags_o,
  output logic [7:0]                   ctrl_o
);

  // ==========================================================================
  // address helpers
  function automatic logic [7:0] port_to_data(input logic [5:0] pa);
    port_to_data = {2'b00, pa} + iosd_pkg::IO_DATA_OFS; // [R2]
  endfunction : port_to_data

  function automatic iosd_pkg::iosd_reg_t decode(input logic [7:0] da);
    if (da == port_to_data(iosd_pkg::STORE0_PORT)) begin
      decode = iosd_pkg::IOSD_STORE0;
    end else if (da == port_to_data(iosd_pkg::STORE1_PORT)) begin
      decode = iosd_pkg::IOSD_STORE1;
    end else if (da == port_to_data(iosd_pkg::STORE2_PORT)) begin
      decode = iosd_pkg::IOSD_STORE2;
    end else if (da == port_to_data(iosd_pkg::FLAGS_PORT)) begin
      decode = iosd_pkg::IOSD_FLAGS;
    end else if (da == iosd_pkg::CTRL_DATA) begin
      decode = iosd_pkg::IOSD_CTRL;
    end else begin
      decode = iosd_pkg::IOSD_NONE; // [R13]
    end
  endfunction : decode

  // ==========================================================================
  // storage
  logic [7:0] store_q [3];
  logic [7:0] flags_q;
  logic [7:0] ctrl_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       test_bit_q;
  logic       test_valid_q;

  // ==========================================================================
  // access merge: data space first, then port path, then bit operations;
  // the core issues one access a cycle, so the order only settles misuse
  logic       acc_rd;
  logic       acc_wr;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic       op_set;
  logic       op_clr;
  logic       op_test;
  logic [7:0] bit_mask;

  always_comb begin
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    acc_addr  = 8'h00;
    acc_wdata = 8'h00;
    op_set    = 1'b0;
    op_clr    = 1'b0;
    op_test   = 1'b0;
    bit_mask  = 8'h00;
    if (data_req_i.rd || data_req_i.wr) begin
      // the full 0x00-0xff data space, extended region included
      acc_rd    = data_req_i.rd; // [R6]
      acc_wr    = data_req_i.wr; // [R6]
      acc_addr  = data_req_i.addr; // [R5]
      acc_wdata = data_req_i.wdata;
    end else if (port_req_i.rd || port_req_i.wr) begin
      // six address bits cannot reach past data address 0x5f
      acc_rd    = port_req_i.rd; // [R1]
      acc_wr    = port_req_i.wr; // [R1]
      acc_addr  = port_to_data(port_req_i.addr); // [R1] [R5]
      acc_wdata = port_req_i.wdata;
    end else if (bit_req_i.set || bit_req_i.clr || bit_req_i.test) begin
      // five address bits keep bit operations inside ports 0x00-0x1f
      acc_addr = port_to_data({1'b0, bit_req_i.addr}); // [R3] [R4]
      op_set   = bit_req_i.set; // [R3]
      op_clr   = bit_req_i.clr && !bit_req_i.set; // [R3]
      op_test  = bit_req_i.test && !bit_req_i.set && !bit_req_i.clr; // [R4]
      bit_mask = 8'h01 << bit_req_i.idx;
    end
  end

  iosd_pkg::iosd_reg_t sel;
  logic [7:0]          cur;

  always_comb begin
    sel = decode(acc_addr);
    case (sel)
      iosd_pkg::IOSD_STORE0: cur = store_q[0];
      iosd_pkg::IOSD_STORE1: cur = store_q[1];
      iosd_pkg::IOSD_STORE2: cur = store_q[2];
      iosd_pkg::IOSD_FLAGS:  cur = flags_q;
      iosd_pkg::IOSD_CTRL:   cur = ctrl_q;
      default:               cur = 8'h00; // [R13]
    endcase
  end

  // ==========================================================================
  // value written to an ordinary register: a bit operation rewrites only the
  // selected bit from the value held in this same cycle
  logic [7:0] rmw_val;

  always_comb begin
    if (op_set) begin
      rmw_val = cur | bit_mask; // [R8]
    end else if (op_clr) begin
      rmw_val = cur & ~bit_mask; // [R8]
    end else begin
      rmw_val = acc_wdata;
    end
  end

  logic any_write;
  assign any_write = acc_wr || op_set || op_clr;

  // ==========================================================================
  // scratch stores
  logic [1:0] store_idx;
  logic       store_hit;

  always_comb begin
    store_hit = 1'b1;
    case (sel)
      iosd_pkg::IOSD_STORE0: store_idx = 2'd0;
      iosd_pkg::IOSD_STORE1: store_idx = 2'd1;
      iosd_pkg::IOSD_STORE2: store_idx = 2'd2;
      default: begin
        store_idx = 2'd0;
        store_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        store_q[i] <= iosd_pkg::STORE_RST; // [R11]
      end
    end else if (any_write && store_hit) begin
      store_q[store_idx] <= rmw_val; // [R11] [R12]
    end
  end

  // ==========================================================================
  // status flags: hardware sets, a written one clears; a bit set operation
  // writes a one to its bit only, so neighbouring flags survive it
  logic [7:0] flag_clr;

  always_comb begin
    flag_clr = 8'h00;
    if (sel == iosd_pkg::IOSD_FLAGS) begin
      if (acc_wr) begin
        flag_clr = acc_wdata; // [R7]
      end else if (op_set) begin
        flag_clr = bit_mask; // [R7] [R8]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_q <= iosd_pkg::FLAGS_RST;
    end else begin
      // a new event in the clearing cycle is kept
      flags_q <= (flags_q & ~flag_clr) | flag_evt_i; // [R7]
    end
  end

  // ==========================================================================
  // extended control register, out of reach of the port path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= iosd_pkg::CTRL_RST;
    end else if (acc_wr && sel == iosd_pkg::IOSD_CTRL) begin
      ctrl_q <= acc_wdata; // [R5] [R6]
    end
  end

  // ==========================================================================
  // read answer, one cycle after the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q  <= iosd_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= acc_rd;
      if (acc_rd) begin
        rdata_q <= cur; // [R6] [R13]
      end
    end
  end

  // ==========================================================================
  // bit test answer; the core decides skip-if-one or skip-if-zero itself
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_bit_q   <= 1'b0;
      test_valid_q <= 1'b0;
    end else begin
      test_valid_q <= op_test; // [R4]
      if (op_test) begin
        test_bit_q <= |(cur & bit_mask); // [R4] [R12]
      end
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o      = rdata_q;
  assign rvalid_o     = rvalid_q;
  assign test_bit_o   = test_bit_q;
  assign test_valid_o = test_valid_q;
  assign flags_o      = flags_q;
  assign ctrl_o       = ctrl_q;

endmodule : iosd_decoder

// ---- verilog/iosd_pkg.sv ----
// constants, types and register map of the peripheral register space decoder
// Functional notes
// [R1] port path uses 6-bit addresses 0x00-0x3F
// [R2] data-space address equals port address plus 0x20
// [R3] ports 0x00-0x1F take single-bit set/clear
// [R4] low ports offer single-bit test for skipping
// [R5] extended 0x60-0xFF reached by load/store only
// [R6] every location readable and writable by load/store
// [R7] status flags clear on one, zero ignored
// [R8] bit set/clear touches only the addressed bit
// [R9] software writes zero into reserved bits
// [R10] software never writes reserved addresses
// [R11] three 8-bit scratch stores, reset to zero
// [R12] low scratch store supports bit set/clear/test
// [R13] unmapped reads zero, unmapped writes ignored
package iosd_pkg;

  // ==========================================================================
  // address space
  localparam int unsigned    PORT_AW     = 6;
  localparam int unsigned    DATA_AW     = 8;
  localparam int unsigned    BIT_AW      = 5;
  localparam logic [7:0]     IO_DATA_OFS = 8'h20;
  localparam logic [7:0]     IO_DATA_TOP = 8'h5f;
  localparam logic [7:0]     EXT_LO      = 8'h60;

  // ==========================================================================
  // register map: port addresses, extended data address
  localparam logic [5:0]     FLAGS_PORT  = 6'h1c;
  localparam logic [5:0]     STORE0_PORT = 6'h1e;
  localparam logic [5:0]     STORE1_PORT = 6'h2a;
  localparam logic [5:0]     STORE2_PORT = 6'h2b;
  localparam logic [7:0]     CTRL_DATA   = 8'h60;

  // ==========================================================================
  // reset values
  localparam logic [7:0]     STORE_RST   = 8'h00;
  localparam logic [7:0]     FLAGS_RST   = 8'h00;
  localparam logic [7:0]     CTRL_RST    = 8'h00;
  localparam logic [7:0]     RDATA_RST   = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    IOSD_NONE   = 3'b000,
    IOSD_STORE0 = 3'b001,
    IOSD_STORE1 = 3'b010,
    IOSD_STORE2 = 3'b011,
    IOSD_FLAGS  = 3'b100,
    IOSD_CTRL   = 3'b101
  } iosd_reg_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iosd_data_req_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } iosd_port_req_t;

  typedef struct packed {
    logic       set;
    logic       clr;
    logic       test;
    logic [4:0] addr;
    logic [2:0] idx;
  } iosd_bit_req_t;

endpackage : iosd_pkg

// ---- verification/iosd_decoder_props.sv ----
// concurrent checks on the ports of the register space decoder
`timescale 1ns/1ps
module iosd_decoder_props (
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  input wire iosd_pkg::iosd_data_req_t data_req_i,
  input wire iosd_pkg::iosd_port_req_t port_req_i,
  input wire iosd_pkg::iosd_bit_req_t  bit_req_i,
  input wire logic [7:0]              flag_evt_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    rvalid_o,
  input wire logic                    test_bit_o,
  input wire logic                    test_valid_o,
  input wire logic [7:0]              flags_o,
  input wire logic [7:0]              ctrl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // bit requests lose to any byte request in the same cycle
  logic busy;
  assign busy = data_req_i.rd | data_req_i.wr | port_req_i.rd | port_req_i.wr;
  // ==========================================================================
  // assertions
  rd_answer_a: assert property (data_req_i.rd || port_req_i.rd &&
    !data_req_i.wr |=> rvalid_o) else $error("read not answered");
  rvalid_cause_a: assert property (rvalid_o |->
    $past(data_req_i.rd | port_req_i.rd)) else $error("spurious rvalid");
  unmapped_zero_a: assert property (data_req_i.rd &&
    data_req_i.addr < 8'h20 |=> rdata_o == 8'h00) else $error("nonzero read");
  ext_write_a: assert property (data_req_i.wr && data_req_i.addr == 8'h60
    |=> ctrl_o == $past(data_req_i.wdata)) else $error("ctrl not stored");
  ext_guard_a: assert property (!(data_req_i.wr &&
    data_req_i.addr == 8'h60) |=> $stable(ctrl_o)) else $error("ctrl moved");
  w1c_clear_a: assert property (data_req_i.wr && data_req_i.addr == 8'h3c
    |=> flags_o == ($past(flags_o) & ~$past(data_req_i.wdata)
    | $past(flag_evt_i))) else $error("flag clear wrong");
  bit_only_a: assert property (!busy && bit_req_i.set &&
    bit_req_i.addr == 5'h1c |=> flags_o == ($past(flags_o) &
    ~(8'h01 << $past(bit_req_i.idx)) | $past(flag_evt_i)))
    else $error("bit op touched other flags");
  test_answer_a: assert property (!busy && bit_req_i.test &&
    !bit_req_i.set && !bit_req_i.clr |=> test_valid_o)
    else $error("test not answered");
endmodule : iosd_decoder_props

// ---- verification/iosd_core_model.sv ----
// processor core model issuing load/store, port and bit requests
`timescale 1ns/1ps
module iosd_core_model (
  input  wire logic                    clk_i,
  output iosd_pkg::iosd_data_req_t     data_req_o,
  output iosd_pkg::iosd_port_req_t     port_req_o,
  output iosd_pkg::iosd_bit_req_t      bit_req_o
);
  initial begin
    data_req_o = '0;
    port_req_o = '0;
    bit_req_o  = '0;
  end
  // one request per cycle, held for the whole cycle; no reserved writes
  task automatic issue(input logic [17:0] d,
                       input logic [15:0] p, input logic [10:0] b);
    @(posedge clk_i);
    #1;
    data_req_o = d;
    port_req_o = p;
    bit_req_o  = b;
  endtask : issue
endmodule : iosd_core_model

// ---- verification/io_space_decoder_tb.sv ----
// self-checking bench for the register space decoder
`timescale 1ns/1ps
module io_space_decoder_tb;
  logic clk, rst_n, rvalid, tbit, tvalid, k;
  logic [7:0] flag_evt, rdata, flags, ctrl, v0;
  logic [7:0] v[3];
  logic [5:0] pa[3] = '{6'h1e, 6'h2a, 6'h2b};
  logic [7:0] rq[$], tq[$];
  int errors = 0, checked = 0;
  iosd_pkg::iosd_data_req_t dreq;
  iosd_pkg::iosd_port_req_t preq;
  iosd_pkg::iosd_bit_req_t  breq;
  iosd_core_model core (.clk_i(clk), .data_req_o(dreq), .port_req_o(preq),
    .bit_req_o(breq));
  iosd_decoder dut (.clk_i(clk), .rst_n_i(rst_n), .data_req_i(dreq),
    .port_req_i(preq), .bit_req_i(breq), .flag_evt_i(flag_evt),
    .rdata_o(rdata), .rvalid_o(rvalid), .test_bit_o(tbit),
    .test_valid_o(tvalid), .flags_o(flags), .ctrl_o(ctrl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic ld(input logic [7:0] a, e);
    rq.push_back(e);
    core.issue({2'b10, a, 8'h00}, '0, '0);
  endtask : ld
  task automatic pin(input logic [5:0] a, input logic [7:0] e);
    rq.push_back(e);
    core.issue('0, {2'b10, a, 8'h00}, '0);
  endtask : pin
  // results are compared as they appear, oldest note first
  always @(negedge clk) begin
    if (rvalid === 1'b1) chk("rdata", rdata, rq.pop_front());
    if (tvalid === 1'b1) chk("tbit", {7'h0, tbit}, tq.pop_front());
  end
  initial begin
    #2_000_000;
    errors++;
    tally_and_finish();
  end
  // ==========================================================================
  // main sequence
  initial begin
    v0 = 8'($urandom(32'he0575d3f));
    rst_n = 1'b0;
    flag_evt = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (pa[i]) ld({2'b00, pa[i]} + 8'h20, 8'h00);
    ld(8'h3c, 8'h00);
    foreach (pa[i]) begin
      v[i] = 8'($urandom);
      core.issue('0, {2'b01, pa[i], v[i]}, '0);
    end
    foreach (pa[i]) begin
      ld({2'b00, pa[i]} + 8'h20, v[i]);
      pin(pa[i], v[i]);
    end
    core.issue({2'b01, 8'h4b, v0 ^ 8'h5a}, '0, '0);
    pin(6'h2b, v0 ^ 8'h5a);
    core.issue({2'b01, 8'h60, v0}, '0, '0);
    ld(8'h60, v0);
    pin(6'h20, 8'h00);
    ld(8'h70, 8'h00);
    ld(8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      k = 1'($urandom);
      core.issue('0, '0, {k, ~k, 1'b0, 5'h1e, i[2:0]});
      v[0][i] = k;
      tq.push_back({7'h0, k});
      core.issue('0, '0, {3'b001, 5'h1e, i[2:0]});
    end
    ld(8'h3e, v[0]);
    core.issue('0, '0, '0);
    chk("ctrl", ctrl, v0);
    @(posedge clk);
    #1 flag_evt = 8'hff;
    @(posedge clk);
    #1 flag_evt = '0;
    core.issue({2'b01, 8'h3c, 8'h05}, '0, '0);
    core.issue('0, '0, {3'b100, 5'h1c, 3'd1});
    core.issue('0, '0, {3'b010, 5'h1c, 3'd3});
    tq.push_back(8'h01);
    core.issue('0, '0, {3'b001, 5'h1c, 3'd3});
    ld(8'h3c, 8'hf8);
    core.issue('0, '0, '0);
    chk("flags", flags, 8'hf8);
    repeat (3) @(posedge clk);
    chk("pending", 8'(rq.size() + tq.size()), 8'h00);
    tally_and_finish();
  end
endmodule : io_space_decoder_tb
bind iosd_decoder iosd_decoder_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .data_req_i(data_req_i), .port_req_i(port_req_i), .bit_req_i(bit_req_i),
  .flag_evt_i(flag_evt_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .test_bit_o(test_bit_o), .test_valid_o(test_valid_o), .flags_o(flags_o),
  .ctrl_o(ctrl_o));
